// ===== inc/lsc_params.svh
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH
`define LSC_CTRL_OFS 5'h00
`define LSC_TIME_OFS 5'h01
`define LSC_CTRL_RST 8'h00
`define LSC_TIME_RST 8'h00
`define LSC_POWER_BIT 0
`define LSC_EN_BIT 1
`define LSC_VALID_BIT 4
`define LSC_INTR_BIT 5
`define LSC_SF_STOP 5'h02
`define LSC_SF_START 5'h03
`define LSC_STEP_TIME_US 2700
`define LSC_CLK_MHZ 10
`define LSC_STEP_CYCLES (`LSC_STEP_TIME_US * `LSC_CLK_MHZ)
`define LSC_FULL_COUNT 9'h100
`endif

// ===== inc/lsc_pkg.sv
package lsc_pkg;
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [4:0] addr;
        logic [7:0] wrData;
    } lsc_bus_s;

    typedef struct packed {
        logic valid;
        logic [4:0] code;
    } lsc_sf_s;

    typedef enum logic [1:0] {
        LSC_IDLE,
        LSC_AUTO,
        LSC_MANUAL
    } lsc_state_e;
endpackage : lsc_pkg

// ===== verilog/lsc_ctrl_timing_regs.sv
`timescale 1ns/10ps
`include "lsc_params.svh"
module lsc_ctrl_timing_regs #(
    parameter int STEP_CYCLES = `LSC_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire lsc_pkg::lsc_bus_s regBus,
    input wire lsc_pkg::lsc_sf_s sfCmd,
    input wire logic intrActive,
    output logic [7:0] rdData,
    output logic coreOn,
    output logic adcRun,
    output logic integrating,
    output logic convDone
);
    import lsc_pkg::*;

    localparam int CW = $clog2(STEP_CYCLES);
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    logic power_ff;
    logic enable_ff;
    logic [7:0] timeReg_ff;
    logic adcRun_ff;
    logic convValid_ff;
    logic [7:0] rdData_ff;
    logic integrating_ff;
    logic convDone_ff;
    lsc_state_e state_ff;
    logic [8:0] remain_ff;
    logic [CW-1:0] stepCnt_ff;
    logic stepTick;
    logic ctrlWr;
    logic timeWr;
    logic sfStart;
    logic sfStop;

    // The step count a timing value asks for; zero is manual and never used here.
    function automatic logic [8:0] steps_for(input logic [7:0] value);
        steps_for = `LSC_FULL_COUNT - {1'b0, value};
    endfunction : steps_for

    assign ctrlWr = regBus.wrEn && (regBus.addr == `LSC_CTRL_OFS);
    assign timeWr = regBus.wrEn && (regBus.addr == `LSC_TIME_OFS);
    assign sfStart = sfCmd.valid && (sfCmd.code == `LSC_SF_START);
    assign sfStop = sfCmd.valid && (sfCmd.code == `LSC_SF_STOP);
    assign stepTick = (state_ff == LSC_AUTO) && (stepCnt_ff == STEP_LAST);

    // Only the power and enable bits are storage; status bits ignore writes.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_ff <= 1'((`LSC_CTRL_RST >> `LSC_POWER_BIT) & 8'h01);
            enable_ff <= 1'((`LSC_CTRL_RST >> `LSC_EN_BIT) & 8'h01);
        end
        else if (ctrlWr)
        begin
            power_ff <= regBus.wrData[`LSC_POWER_BIT];
            enable_ff <= regBus.wrData[`LSC_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            timeReg_ff <= `LSC_TIME_RST;
        else if (timeWr)
            timeReg_ff <= regBus.wrData;
    end

    // The channels run only while the core is powered and enabled.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            adcRun_ff <= 1'b0;
        else
            adcRun_ff <= power_ff && enable_ff;
    end

    // Step divider: one tick per 2.7 ms while timed integration runs.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            stepCnt_ff <= '0;
        else if (state_ff != LSC_AUTO || stepTick)
            stepCnt_ff <= '0;
        else
            stepCnt_ff <= stepCnt_ff + 1'b1;
    end

    // Integration sequencing for both channels at once.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= LSC_IDLE;
            remain_ff <= '0;
            integrating_ff <= 1'b0;
            convDone_ff <= 1'b0;
        end
        else
        begin
            convDone_ff <= 1'b0;
            case (state_ff)
                LSC_IDLE:
                begin
                    if (adcRun_ff && timeReg_ff != 8'h00)
                    begin
                        state_ff <= LSC_AUTO;
                        remain_ff <= steps_for(timeReg_ff);
                        integrating_ff <= 1'b1;
                    end
                    else if (adcRun_ff && sfStart)
                    begin
                        state_ff <= LSC_MANUAL;
                        integrating_ff <= 1'b1;
                    end
                end
                LSC_AUTO:
                begin
                    if (!adcRun_ff)
                    begin
                        state_ff <= LSC_IDLE;
                        integrating_ff <= 1'b0;
                    end
                    else if (stepTick && remain_ff == 9'h001)
                    begin
                        convDone_ff <= 1'b1;
                        if (timeReg_ff == 8'h00)
                        begin
                            state_ff <= LSC_IDLE;
                            integrating_ff <= 1'b0;
                        end
                        else
                            remain_ff <= steps_for(timeReg_ff);
                    end
                    else if (stepTick)
                        remain_ff <= remain_ff - 9'h001;
                end
                LSC_MANUAL:
                begin
                    if (!adcRun_ff)
                    begin
                        state_ff <= LSC_IDLE;
                        integrating_ff <= 1'b0;
                    end
                    else if (sfStop)
                    begin
                        state_ff <= LSC_IDLE;
                        integrating_ff <= 1'b0;
                        convDone_ff <= 1'b1;
                    end
                end
                default:
                begin
                    state_ff <= LSC_IDLE;
                    integrating_ff <= 1'b0;
                end
            endcase
        end
    end

    // A completed integration sets valid; losing power or enable clears it.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            convValid_ff <= 1'b0;
        else if (convDone_ff)
            convValid_ff <= 1'b1;
        else if (!adcRun_ff)
            convValid_ff <= 1'b0;
    end

    // Read data appears one cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdData_ff <= 8'h00;
        else if (regBus.rdEn)
        begin
            if (regBus.addr == `LSC_CTRL_OFS)
            begin
                rdData_ff <= 8'h00;
                rdData_ff[`LSC_POWER_BIT] <= power_ff;
                rdData_ff[`LSC_EN_BIT] <= enable_ff;
                rdData_ff[`LSC_VALID_BIT] <= convValid_ff;
                rdData_ff[`LSC_INTR_BIT] <= intrActive;
            end
            else if (regBus.addr == `LSC_TIME_OFS)
                rdData_ff <= timeReg_ff;
            else
                rdData_ff <= 8'h00;
        end
    end

    assign rdData = rdData_ff;
    assign coreOn = power_ff;
    assign adcRun = adcRun_ff;
    assign integrating = integrating_ff;
    assign convDone = convDone_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic timeWritten_ff;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            timeWritten_ff <= 1'b0;
        else if (timeWr)
            timeWritten_ff <= 1'b1;
    end

    sequence sManualStart;
        state_ff == LSC_IDLE && adcRun_ff && timeReg_ff == 8'h00 && sfStart;
    endsequence
    sequence sManualStop;
        state_ff == LSC_MANUAL && adcRun_ff && sfStop;
    endsequence

    a_power_write: assert property (ctrlWr |=>
        coreOn == $past(regBus.wrData[`LSC_POWER_BIT]))
        else $error("Power bit did not follow the control write.");
    a_enable_start: assert property (
        $rose(adcRun_ff) && timeReg_ff != 8'h00 |=> integrating)
        else $error("Timed integration did not start on enable.");
    a_disable_stop: assert property (!adcRun_ff |=> !integrating)
        else $error("Integration continued after disable.");
    // Valid may only stand one cycle past a running channel or a completed integration.
    a_valid_needs_run: assert property (
        convValid_ff |-> $past(adcRun_ff) || $past(convDone_ff))
        else $error("Valid shown without power and enable.");
    a_step_tick: assert property (
        state_ff == LSC_AUTO && stepCnt_ff != STEP_LAST |=>
        remain_ff == $past(remain_ff) || !adcRun_ff || convDone)
        else $error("Step count moved before a full step elapsed.");
    a_time_reset: assert property (!timeWritten_ff |-> timeReg_ff == 8'h00)
        else $error("Timing register left zero without a write.");
    a_manual_begin: assert property (
        sManualStart |=> state_ff == LSC_MANUAL && integrating)
        else $error("Manual start code did not begin integration.");
    a_manual_end: assert property (sManualStop |=> convDone ##1 convValid_ff)
        else $error("Manual stop code did not end integration.");
    a_step_load: assert property (
        $rose(integrating) && state_ff == LSC_AUTO |->
        remain_ff == `LSC_FULL_COUNT - {1'b0, $past(timeReg_ff)})
        else $error("Loaded step count is not 256 minus the timing value.");
    a_status_read: assert property (
        regBus.rdEn && regBus.addr == `LSC_CTRL_OFS |=>
        rdData[`LSC_INTR_BIT] == $past(intrActive) &&
        rdData[`LSC_VALID_BIT] == $past(convValid_ff) && rdData[3:2] == 2'b00)
        else $error("Control read did not show live status.");
endmodule : lsc_ctrl_timing_regs

// ===== testbench/lsc_host_model.sv
`timescale 1ns/10ps
module lsc_host_model
(
    input wire logic ref_clk,
    input wire logic [7:0] rdData,
    output lsc_pkg::lsc_bus_s regBus,
    output lsc_pkg::lsc_sf_s sfCmd,
    output logic intrActive
);
    import lsc_pkg::*;

    initial
    begin
        regBus = '0;
        sfCmd = '0;
        intrActive = 1'b0;
    end

    // Register accesses are plain byte writes and reads, so no send-byte value limit applies.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        regBus = {1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        #1;
        regBus = '0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        regBus = {1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        #1;
        regBus = '0;
        d = rdData;
    endtask : rd

    task automatic sf(input logic [4:0] c);
        @(posedge ref_clk);
        #1;
        sfCmd = {1'b1, c};
        @(posedge ref_clk);
        #1;
        sfCmd = '0;
    endtask : sf

    // Drives the interrupt level just after an edge, like the interrupt logic would.
    task automatic set_intr(input logic lvl);
        @(posedge ref_clk);
        #1;
        intrActive = lvl;
    endtask : set_intr

    // Powers the core and lets it settle for 2 ms before any enable.
    task automatic power_up();
        wr(5'h00, 8'h01);
        repeat (20000) @(posedge ref_clk);
    endtask : power_up
endmodule : lsc_host_model

// ===== testbench/lsc_ctrl_timing_regs_tb.sv
`timescale 1ns/10ps
module lsc_ctrl_timing_regs_tb;
    import lsc_pkg::*;
    logic ref_clk;
    logic sys_rst;
    lsc_bus_s regBus;
    lsc_sf_s sfCmd;
    logic intrActive;
    logic [7:0] rdData;
    logic coreOn;
    logic adcRun;
    logic integrating;
    logic convDone;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] v;
    int n;
    int p1;
    int p2;

    lsc_ctrl_timing_regs #(.STEP_CYCLES(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .regBus(regBus), .sfCmd(sfCmd), .intrActive(intrActive), .rdData(rdData),
        .coreOn(coreOn), .adcRun(adcRun), .integrating(integrating), .convDone(convDone));

    lsc_host_model host (.ref_clk(ref_clk), .rdData(rdData), .regBus(regBus),
        .sfCmd(sfCmd), .intrActive(intrActive));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // Counts cycles up to and including the next end-of-integration pulse.
    task automatic wait_done(output int c);
        c = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            c++;
        end while (convDone !== 1'b1 && c < 2000);
        chk("convDone seen", 8'h01, {7'h00, convDone});
    endtask : wait_done

    task automatic t_reset();
        host.rd(5'h00, v);
        chk("ctrl reset", 8'h00, v);
        host.rd(5'h01, v);
        chk("timing reset", 8'h00, v);
        chk("outputs reset", 8'h00, {4'h0, coreOn, adcRun, integrating, convDone});
    endtask : t_reset

    task automatic t_power();
        host.wr(5'h01, 8'hff);
        host.power_up();
        chk("coreOn", 8'h01, {7'h00, coreOn});
        host.wr(5'h00, 8'hfd);
        host.rd(5'h00, v);
        chk("ctrl masked", 8'h01, v);
        host.set_intr(1'b1);
        host.rd(5'h00, v);
        chk("ctrl intr", 8'h21, v);
        host.set_intr(1'b0);
    endtask : t_power

    task automatic t_auto();
        host.wr(5'h00, 8'h03);
        @(posedge ref_clk);
        #1;
        chk("adcRun", 8'h01, {7'h00, adcRun});
        wait_done(n);
        wait_done(p1);
        host.rd(5'h00, v);
        chk("ctrl valid", 8'h13, v);
        host.wr(5'h01, 8'hfe);
        wait_done(n);
        wait_done(p2);
        chk("one step longer", 8'h04, 8'(p2 - p1));
    endtask : t_auto

    task automatic t_stop();
        host.wr(5'h00, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("integrating off", 8'h00, {7'h00, integrating});
        n = 0;
        repeat (30)
        begin
            @(posedge ref_clk);
            #1;
            n += int'(convDone === 1'b1);
        end
        chk("no conversions", 8'h00, 8'(n));
        host.rd(5'h00, v);
        chk("valid cleared", 8'h01, v);
    endtask : t_stop

    task automatic t_manual();
        host.wr(5'h01, 8'h00);
        host.wr(5'h00, 8'h03);
        host.sf(5'h07);
        chk("odd code", 8'h00, {7'h00, integrating});
        host.sf(5'h03);
        chk("manual start", 8'h01, {7'h00, integrating});
        host.sf(5'h02);
        chk("manual stop", 8'h01, {6'h00, integrating, convDone});
        @(posedge ref_clk);
        #1;
        host.rd(5'h00, v);
        chk("manual valid", 8'h13, v);
    endtask : t_manual

    initial
    begin
        #4000000;
        err_total++;
        $display("BAD watchdog expired");
        end_sim();
    end

    initial
    begin
        sys_rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_power();
        t_auto();
        t_stop();
        t_manual();
        end_sim();
    end
endmodule : lsc_ctrl_timing_regs_tb
